// ### pkg/mac_bank_defs.svh
/*
  constants of the multiply-accumulator bank-state controller:
  register select codes, status codes, command values.
  assumes it is included by bare name wherever these are needed.
*/
`ifndef MAC_BANK_DEFS_SVH
`define MAC_BANK_DEFS_SVH

// width of the register select code
`define SEL_W 4
// register select codes seen on the cpu access port
`define SEL_STATUS 4'h0
`define SEL_CONTROL 4'h1
`define SEL_ACC0 4'h2
`define SEL_ACC1 4'h3
`define SEL_ACC2 4'h4
`define SEL_ACC3 4'h5
`define SEL_ACC4 4'h6
`define SEL_OTHER 4'h7

// data bank status codes, status bits 1:0
`define DATA_EMPTY 2'h0
`define DATA_READY 2'h1
`define DATA_DONE 2'h3

// calc bank status codes, status bits 3:2
`define CALC_EMPTY 2'h0
`define CALC_BUSY 2'h2
`define CALC_DONE 2'h3

// status write value that forces a bank swap
`define FORCE_SWAP_VAL 8'h80

// reset values
`define DATA_RST `DATA_EMPTY
`define CALC_RST `CALC_EMPTY
`define BANK_SEL_RST 1'h0

`endif

// ### pkg/mac_bank_pkg.sv
/*
  types of the bank-state controller: the two bank status enums
  and the decode helper for accumulator byte selects.
  assumes mac_bank_defs.svh is on the include path.
*/
`include "mac_bank_defs.svh"

package mac_bank_pkg;

  // data bank status, 10 is never produced
  typedef enum logic [1:0] {
    D_EMPTY = `DATA_EMPTY,
    D_READY = `DATA_READY,
    D_DONE = `DATA_DONE
  } data_state_t;

  // calc bank status, 01 is never produced
  typedef enum logic [1:0] {
    C_EMPTY = `CALC_EMPTY,
    C_BUSY = `CALC_BUSY,
    C_DONE = `CALC_DONE
  } calc_state_t;

  // true for any of the five accumulator byte selects
  function automatic logic is_acc_byte(input logic [`SEL_W-1:0] sel);
    is_acc_byte = (sel >= `SEL_ACC0) && (sel <= `SEL_ACC4);
  endfunction

endpackage

// ### rtl/bank_event_decode.sv
/*
  turns one cpu register access into the bank-level events:
  job loaded, result read, result discarded, forced swap.
  assumes one access per cycle with select, block and last flags valid.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mac_bank_defs.svh"

module bank_event_decode
  import mac_bank_pkg::*;
(
  input wire logic wr,                    // cpu write strobe
  input wire logic rd,                    // cpu read strobe
  input wire logic blk,                   // access belongs to a block transfer
  input wire logic last,                  // final access of the block transfer
  input wire logic [`SEL_W-1:0] sel,      // register select code
  input wire logic [7:0] wdata,           // write data
  output logic load_done,                 // new job fully written
  output logic read_done,                 // result fully read
  output logic discard,                   // write that drops a held result
  output logic force_swap                 // status write of the swap value
);

  // pure decode, the caller registers everything
  always_comb begin
    // block write ending on control or an accumulator byte, or lone top byte write
    load_done = wr && ((blk && last && ((sel == `SEL_CONTROL) || is_acc_byte(sel))) ||
                       (!blk && (sel == `SEL_ACC4)));
    // block read ending on an accumulator byte, or lone top byte read
    read_done = rd && ((blk && last && is_acc_byte(sel)) || (!blk && (sel == `SEL_ACC4)));
    // every write except to the status register counts
    discard = wr && (sel != `SEL_STATUS);
    // only the exact swap value on the status register
    force_swap = wr && (sel == `SEL_STATUS) && (wdata == `FORCE_SWAP_VAL);
  end

endmodule

`default_nettype wire

// ### rtl/mac_bank_state_control.sv
/*
  bank-state controller of the multiply-accumulator: tracks the
  data bank (cpu side) and calc bank (engine side), swaps them and
  starts queued jobs.
  assumes cpu accesses arrive as one-cycle strobes synchronous to clk
  and the engine reports completion with a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mac_bank_defs.svh"

// Behaviour
// R1: empty data, done calc, load: swap, start
// R2: lone top byte write completes a load
// R3: ready data, engine finishes: swap, keep busy
// R4: done data, engine finishes: calc done
// R5: done data, block read ends: data empty
// R6: done data, top byte read: data empty
// R7: done data, non-status write: data empty
// R8: status bits 1:0 carry data code
// R9: status bits 3:2 carry calc code
// R10: empty data, done calc, 80h: swap
// R11: both empty, load: swap, calc busy
// R12: invalid status codes never produced
module mac_bank_state_control
  import mac_bank_pkg::*;
(
  input wire logic clk,                   // system clock, 100 MHz
  input wire logic nrst,                  // async reset, active low
  input wire logic cpu_wr,                // cpu register write strobe
  input wire logic cpu_rd,                // cpu register read strobe
  input wire logic cpu_blk,               // access is part of a block transfer
  input wire logic cpu_last,              // final access of that block transfer
  input wire logic [`SEL_W-1:0] cpu_sel,  // register select code
  input wire logic [7:0] cpu_wdata,       // cpu write data
  input wire logic calc_finish,           // engine finished its job, pulse
  output var data_state_t data_status,    // data bank status code
  output var calc_state_t calc_status,    // calc bank status code
  output logic [3:0] bank_status,         // status register image
  output logic data_bank_sel,             // physical bank now facing the cpu
  output logic bank_swap,                 // banks swapped, pulse
  output logic calc_start                 // engine starts a job, pulse
);

  // decoded cpu events
  logic load_done;   // job written to data bank
  logic read_done;   // result taken by the cpu
  logic discard;     // write drops a held result
  logic force_swap;  // status written with swap value

  // next values of the state group
  data_state_t next_data;      // next data bank status
  calc_state_t next_calc;      // next calc bank status
  logic next_bank_sel;         // next physical bank mapping
  logic next_swap;             // swap happens this cycle
  logic next_start;            // engine start this cycle
  logic engine_done;           // finish pulse qualified by a running job

  // access decode kept apart so the transition logic stays readable
  bank_event_decode u_decode (
    .wr(cpu_wr),
    .rd(cpu_rd),
    .blk(cpu_blk),
    .last(cpu_last),
    .sel(cpu_sel),
    .wdata(cpu_wdata),
    .load_done(load_done),
    .read_done(read_done),
    .discard(discard),
    .force_swap(force_swap)
  );

  // a stray finish while nothing runs is ignored
  assign engine_done = calc_finish && (calc_status == C_BUSY);

  // transition logic: engine first, then cpu discard, then cpu load
  always_comb begin
    next_data = data_status;
    next_calc = calc_status;
    next_swap = 1'h0;
    next_start = 1'h0;
    // engine completion
    if (engine_done) begin
      if (data_status == D_READY) begin
        // R3: queued job follows at once
        next_data = D_DONE;
        next_calc = C_BUSY;
        next_swap = 1'h1;
        next_start = 1'h1;
      end else begin
        // R4: result stays in calc bank
        next_calc = C_DONE;
      end
    end
    // only a result that was already there can be dropped,
    // so a result landing this very cycle survives the access
    if (data_status == D_DONE) begin
      // R5: block read drains result
      // R6: top byte read drains result
      // R7: non-status write drops result
      if (read_done || discard) begin
        next_data = D_EMPTY;
      end
    end
    // job load into an empty data bank
    if (load_done && (next_data == D_EMPTY)) begin
      case (next_calc)
        C_EMPTY: begin
          // R11: idle engine takes the job
          next_calc = C_BUSY;
          next_swap = 1'h1;
          next_start = 1'h1;
        end
        C_BUSY: begin
          // engine busy, job waits
          next_data = D_READY;
        end
        C_DONE: begin
          // R1: old result comes back, job runs
          // R2: top byte write arrives here too
          next_data = D_DONE;
          next_calc = C_BUSY;
          next_swap = 1'h1;
          next_start = 1'h1;
        end
        default: begin
          // R12: stray code falls back to empty
          next_calc = C_EMPTY;
        end
      endcase
    end else if (load_done && (next_data == D_READY)) begin
      // rewriting a queued job keeps it queued
      next_data = D_READY;
    end
    // forced swap hands a finished result to the cpu
    // R10: swap on swap value
    if (force_swap && (data_status == D_EMPTY) && (calc_status == C_DONE) && !load_done) begin
      next_data = D_DONE;
      next_calc = C_EMPTY;
      next_swap = 1'h1;
    end
    // limitation: a load in the same cycle as a result arrival is not queued
  end

  // bank mapping flips on every swap
  always_comb begin
    next_bank_sel = next_swap ? !data_bank_sel : data_bank_sel;
  end

  // state and pulse registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_status <= D_EMPTY;
      calc_status <= C_EMPTY;
      bank_status <= {`CALC_RST, `DATA_RST};
      data_bank_sel <= `BANK_SEL_RST;
      bank_swap <= 1'h0;
      calc_start <= 1'h0;
    end else begin
      data_status <= next_data;
      calc_status <= next_calc;
      // R8: data code in low bits
      // R9: calc code in high bits
      bank_status <= {next_calc, next_data};
      data_bank_sel <= next_bank_sel;
      bank_swap <= next_swap;
      calc_start <= next_start;
    end
  end

  // checks on the bank behaviour

  chk_no_bad_code: assert property (@(posedge clk) disable iff (!nrst) // R12
    (bank_status[1:0] != 2'h2) && (bank_status[3:2] != 2'h1))
    else $error("invalid bank status code");

  chk_status_image: assert property (@(posedge clk) disable iff (!nrst) // R8
    bank_status == {calc_status, data_status})
    else $error("status image differs from bank state");

  chk_ready_finish: assert property (@(posedge clk) disable iff (!nrst) // R3
    (data_status == D_READY && calc_status == C_BUSY && calc_finish)
    |=> (data_status == D_DONE && calc_status == C_BUSY && bank_swap && calc_start))
    else $error("queued job did not follow completion");

  chk_done_finish: assert property (@(posedge clk) disable iff (!nrst) // R4
    (data_status == D_DONE && calc_status == C_BUSY && calc_finish && !load_done)
    |=> (calc_status == C_DONE && !bank_swap))
    else $error("finish with held result did not mark calc done");

  chk_idle_load: assert property (@(posedge clk) disable iff (!nrst) // R11
    (data_status == D_EMPTY && calc_status == C_EMPTY && load_done)
    |=> (data_status == D_EMPTY && calc_status == C_BUSY && calc_start
         && data_bank_sel != $past(data_bank_sel)))
    else $error("load into idle controller did not start");

  chk_return_load: assert property (@(posedge clk) disable iff (!nrst) // R1
    (data_status == D_EMPTY && calc_status == C_DONE && load_done && !calc_finish)
    |=> (data_status == D_DONE && calc_status == C_BUSY && bank_swap))
    else $error("load over finished calc did not swap");

  chk_top_write: assert property (@(posedge clk) disable iff (!nrst) // R2
    (cpu_wr && !cpu_blk && cpu_sel == `SEL_ACC4 && data_status == D_EMPTY
     && calc_status == C_EMPTY) |=> calc_start)
    else $error("top byte write did not complete a load");

  chk_read_drain: assert property (@(posedge clk) disable iff (!nrst) // R5
    (data_status == D_DONE && read_done) |=> (data_status == D_EMPTY))
    else $error("result read did not empty data bank");

  chk_top_read: assert property (@(posedge clk) disable iff (!nrst) // R6
    (data_status == D_DONE && cpu_rd && !cpu_blk && cpu_sel == `SEL_ACC4)
    |=> (data_status == D_EMPTY))
    else $error("top byte read did not empty data bank");

  chk_write_drop: assert property (@(posedge clk) disable iff (!nrst) // R7
    (data_status == D_DONE && cpu_wr && cpu_sel != `SEL_STATUS && !load_done)
    |=> (data_status == D_EMPTY && (calc_status == $past(calc_status)
         || $past(engine_done))))
    else $error("write did not drop held result");

  // a load right behind the forced swap may legally swap once more
  chk_force_swap: assert property (@(posedge clk) disable iff (!nrst) // R10
    (data_status == D_EMPTY && calc_status == C_DONE && force_swap)
    |=> (data_status == D_DONE && calc_status == C_EMPTY && bank_swap
         ##1 (!bank_swap || $past(load_done))))
    else $error("forced swap failed");

endmodule

`default_nettype wire

// ### tb/engine_model.sv
/*
  behavioural model of the arithmetic engine behind the bank controller:
  starts a job on calc_start and reports completion lat+1 cycles after the start pulse is taken.
  assumes calc_start is a one-cycle pulse and the bench owns lat.
*/
`timescale 1ns/1ps
`default_nettype none

module engine_model (
  input wire logic clk,         // system clock
  input wire logic nrst,        // async reset, active low
  input wire logic calc_start,  // job start pulse from the controller
  input wire logic [7:0] lat,   // cycles per job, zero stalls the engine
  output logic calc_finish      // job done, one-cycle pulse
);
  logic busy;       // a job is running
  logic [7:0] cnt;  // cycles spent on the current job

  // job timer; a stall (lat zero) lets the bench hold results back at will
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'h0;
      cnt <= 8'h00;
      calc_finish <= 1'h0;
    end else begin
      // never pulse twice for one job
      calc_finish <= busy && !calc_finish && (lat != 8'h00) && (cnt >= lat);
      if (calc_start) begin
        busy <= 1'h1;
        cnt <= 8'h00;
      end else if (calc_finish) begin
        busy <= 1'h0;
      end else if (busy) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
/*
  self-checking bench of the bank-state controller: a table of cpu
  accesses and engine completions with the status each should leave.
  assumes the engine model sits on the far side of calc_start/calc_finish.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mac_bank_defs.svh"

`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e); end end

module tb
  import mac_bank_pkg::*;
;
  // one step: access (1 write, 2 read) or engine completion, then outcome
  typedef struct packed {
    logic [1:0] op; logic blk; logic last; logic [3:0] sel; logic [7:0] wd;
    logic fin; logic [3:0] ex; logic sw; logic st;
  } row_t;

  logic clk = 1'h0;          // 100 MHz clock
  logic nrst = 1'h0;         // reset, active low
  logic cpu_wr = 1'h0;       // write strobe
  logic cpu_rd = 1'h0;       // read strobe
  logic cpu_blk = 1'h0;      // block transfer flag
  logic cpu_last = 1'h0;     // last access of block
  logic [3:0] cpu_sel = 4'h0;   // register select
  logic [7:0] cpu_wdata = 8'h00; // write data
  logic [7:0] lat = 8'h00;   // engine latency, zero stalls it
  logic calc_finish;         // from the engine model
  data_state_t data_status;  // data bank code
  calc_state_t calc_status;  // calc bank code
  logic [3:0] bank_status;   // status image
  logic data_bank_sel;       // bank facing the cpu
  logic bank_swap;           // swap pulse
  logic calc_start;          // start pulse
  logic exp_sel = 1'h0;      // expected bank side
  int n_mismatch = 0;        // mismatches seen
  int compares = 0;          // comparisons made
  int cycles = 0;            // run length guard
  int k;                     // wait counter
  row_t rows[22];            // ordinary cases

  always #5 clk = ~clk;

  mac_bank_state_control dut (.clk(clk), .nrst(nrst), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_blk(cpu_blk), .cpu_last(cpu_last), .cpu_sel(cpu_sel), .cpu_wdata(cpu_wdata),
    .calc_finish(calc_finish), .data_status(data_status), .calc_status(calc_status),
    .bank_status(bank_status), .data_bank_sel(data_bank_sel), .bank_swap(bank_swap),
    .calc_start(calc_start));

  engine_model engine (.clk(clk), .nrst(nrst), .calc_start(calc_start), .lat(lat),
    .calc_finish(calc_finish));

  // print counts and verdict, then stop
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one access or one released completion, strobes held a single cycle
  task automatic step(input row_t r);
    @(negedge clk);
    cpu_wr = (r.op == 2'h1);
    cpu_rd = (r.op == 2'h2);
    cpu_blk = r.blk;
    cpu_last = r.last;
    cpu_sel = r.sel;
    cpu_wdata = r.wd;
    if (r.fin) begin
      // release the engine only until its pulse shows
      lat = 8'h01;
      k = 0;
      while (calc_finish !== 1'h1 && k < 20) begin
        @(negedge clk);
        k++;
      end
      // a wait that runs out is a failure of its own
      if (calc_finish !== 1'h1) begin
        n_mismatch++;
        $display("unexpected at %0t: engine never finished", $time);
      end
      lat = 8'h00;
    end
    @(negedge clk);
    {cpu_wr, cpu_rd, cpu_blk, cpu_last} = 4'h0;
  endtask

  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("unexpected at %0t: run timed out", $time);
      summarize();
    end
  end

  initial begin
    rows = '{
      '{1, 0, 0, `SEL_ACC4, 0, 0, 4'h8, 1, 1},     // lone top byte write
      '{1, 1, 1, `SEL_CONTROL, 0, 0, 4'h9, 0, 0},  // queue while busy
      '{0, 0, 0, 0, 0, 1, 4'hB, 1, 1},             // swap, queued job starts
      '{0, 0, 0, 0, 0, 1, 4'hF, 0, 0},             // calc done, no swap
      '{2, 1, 1, `SEL_ACC0, 0, 0, 4'hC, 0, 0},     // block read ends on byte
      '{1, 0, 0, `SEL_STATUS, 8'h80, 0, 4'h3, 1, 0}, // forced swap
      '{1, 0, 0, `SEL_OTHER, 0, 0, 4'h0, 0, 0},    // write drops result
      '{1, 0, 0, `SEL_ACC0, 0, 0, 4'h0, 0, 0},     // lone low byte write, no load
      '{1, 1, 0, `SEL_CONTROL, 0, 0, 4'h0, 0, 0},  // block write not last, no load
      '{1, 1, 1, `SEL_ACC2, 0, 0, 4'h8, 1, 1},     // block ends on byte
      '{0, 0, 0, 0, 0, 1, 4'hC, 0, 0},             // finish with data empty
      '{1, 1, 1, `SEL_CONTROL, 0, 0, 4'hB, 1, 1},  // load swaps out result
      '{2, 0, 0, `SEL_ACC4, 0, 0, 4'h8, 0, 0},     // top byte read
      '{0, 0, 0, 0, 0, 1, 4'hC, 0, 0},             // finish again
      '{1, 0, 0, `SEL_STATUS, 8'h40, 0, 4'hC, 0, 0}, // other value ignored
      '{1, 0, 0, `SEL_STATUS, 8'h80, 0, 4'h3, 1, 0}, // forced swap
      '{1, 0, 0, `SEL_STATUS, 8'h80, 0, 4'h3, 0, 0}, // status write keeps result
      '{2, 1, 0, `SEL_ACC1, 0, 0, 4'h3, 0, 0},     // read not last
      '{2, 1, 1, `SEL_CONTROL, 0, 0, 4'h3, 0, 0},  // last read not a byte
      '{2, 1, 1, `SEL_ACC3, 0, 0, 4'h0, 0, 0},     // block read ends on byte
      '{1, 1, 1, `SEL_ACC4, 0, 0, 4'h8, 1, 1},     // idle load
      '{0, 0, 0, 0, 0, 1, 4'hC, 0, 0}};            // finish with data empty
    repeat (5) @(posedge clk);
    `CHK(bank_status, 4'h0, "reset status") // reset image
    @(negedge clk);
    nrst = 1'h1;
    foreach (rows[i]) begin
      step(rows[i]);
      exp_sel ^= rows[i].sw;
      `CHK(bank_status, rows[i].ex, "status image") // image bits
      `CHK({calc_status, data_status}, rows[i].ex, "bank codes") // legal codes
      `CHK(bank_swap, rows[i].sw, "swap pulse") // swap
      `CHK(calc_start, rows[i].st, "start pulse") // start
      `CHK(data_bank_sel, exp_sel, "bank side") // swap flips side
    end
    // back to back loads with a prompt engine: queue, then both results
    lat = 8'h03;
    @(negedge clk);
    {cpu_wr, cpu_sel} = {1'h1, `SEL_ACC4};
    @(negedge clk);
    @(negedge clk);
    cpu_wr = 1'b0;
    `CHK(bank_status, 4'h9, "back to back load") // second write queues
    k = 0;
    while (bank_status !== 4'hF && k < 50) begin
      @(negedge clk);
      k++;
    end
    `CHK(bank_status, 4'hF, "both results") // chained jobs
    // reset in mid-run clears everything, then an immediate load
    nrst = 1'h0;
    @(negedge clk);
    `CHK({bank_status, data_bank_sel, bank_swap, calc_start}, 7'h00, "mid reset") // reset
    nrst = 1'h1;
    step('{1, 0, 0, `SEL_ACC4, 0, 0, 4'h8, 1, 1});
    `CHK(bank_status, 4'h8, "load after reset") // idle load
    summarize();
  end
endmodule
`default_nettype wire
